// ==== core/pss_top.sv ====
// pressure sensor readout and status registers behind an apb slave
// Overview of operation
// RQ1: threshold bit 7 when level at watermark
// RQ2: overrun bit 6 when full sample overwritten
// RQ3: six-bit unread sample count, 32 full
// RQ4: overwrite shows threshold, overrun, full count
// RQ5: temperature overrun bit 5 on replace
// RQ6: pressure overrun bit 4 on replace
// RQ7: temperature available bit 1 on fresh result
// RQ8: pressure available bit 0 on fresh result
// RQ9: sample status refreshed each data period
// RQ10: 24-bit pressure over three bytes
// RQ11: pressure minus stored offset, modes off
// RQ12: 16-bit temperature over two bytes
// RQ13: filter reset register read restarts filter
// RQ14: watermark from queue control low bits
// RQ15: offset scaled by 256 before subtract
// RQ16: reading results clears available and overrun
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pss_pkg::pss_press_t press_sample,
   input wire pss_pkg::pss_temp_t temp_sample,
   input wire logic odr_tick,
   input wire logic queue_push,
   input wire logic queue_pop
);
   function automatic logic [9:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction

   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] queue_ctrl_q;
   logic [7:0] offset_low_q;
   logic [7:0] offset_high_q;
   logic [7:0] mode_ctrl_q;
   logic [7:0] sample_status_q;
   logic [23:0] press_result_q;
   logic [15:0] temp_result_q;
   logic p_da_q;
   logic p_or_q;
   logic t_da_q;
   logic t_or_q;
   logic lpf_valid;
   logic [23:0] lpf_data;
   pss_pkg::pss_queue_stat_t queue_stat;

   // apb access phase, answered one cycle after penable rises
   wire access = psel & penable & ~pready_q;
   wire wr = access & pwrite & pstrb[0];
   wire rd = access & ~pwrite;

   wire hit_qctrl = (paddr == reg_addr(`PSS_IDX_QUEUE_CTRL));
   wire hit_offl = (paddr == reg_addr(`PSS_IDX_OFFSET_LOW));
   wire hit_offh = (paddr == reg_addr(`PSS_IDX_OFFSET_HIGH));
   wire hit_qstat = (paddr == reg_addr(`PSS_IDX_QUEUE_STATUS));
   wire hit_sstat = (paddr == reg_addr(`PSS_IDX_SAMPLE_STATUS));
   wire hit_pl = (paddr == reg_addr(`PSS_IDX_PRESS_LOW));
   wire hit_pm = (paddr == reg_addr(`PSS_IDX_PRESS_MID));
   wire hit_ph = (paddr == reg_addr(`PSS_IDX_PRESS_HIGH));
   wire hit_tl = (paddr == reg_addr(`PSS_IDX_TEMP_LOW));
   wire hit_th = (paddr == reg_addr(`PSS_IDX_TEMP_HIGH));
   wire hit_lpfr = (paddr == reg_addr(`PSS_IDX_FILTER_RESET));
   wire hit_mode = (paddr == reg_addr(`PSS_IDX_MODE_CTRL));
   wire mapped = hit_qctrl | hit_offl | hit_offh | hit_qstat | hit_sstat | hit_pl | hit_pm |
                 hit_ph | hit_tl | hit_th | hit_lpfr | hit_mode;

   // RQ10 pressure byte lanes
   // RQ12 temperature byte lanes
   wire [7:0] rd_byte = hit_qctrl ? queue_ctrl_q :
                        hit_offl ? offset_low_q :
                        hit_offh ? offset_high_q :
                        hit_qstat ? queue_stat :
                        hit_sstat ? sample_status_q :
                        hit_pl ? press_result_q[7:0] :
                        hit_pm ? press_result_q[15:8] :
                        hit_ph ? press_result_q[23:16] :
                        hit_tl ? temp_result_q[7:0] :
                        hit_th ? temp_result_q[15:8] :
                        hit_mode ? mode_ctrl_q : `PSS_RST_BYTE;

   // RQ16 read clears flags
   wire p_clr = rd & hit_ph;
   wire t_clr = rd & hit_th;
   // RQ13 read restarts filter
   wire lpf_restart = rd & hit_lpfr & mode_ctrl_q[`PSS_MODE_LPF_BIT];

   wire any_mode = mode_ctrl_q[`PSS_MODE_DIFF_BIT] | mode_ctrl_q[`PSS_MODE_AZERO_BIT] |
                   mode_ctrl_q[`PSS_MODE_AREF_BIT];
   // RQ15 offset times 256
   wire [23:0] offset_scaled = {offset_high_q, offset_low_q, 8'h00};
   // RQ11 offset subtraction
   wire [23:0] press_d = any_mode ? lpf_data : lpf_data - offset_scaled;

   wire p_new = lpf_valid;
   wire t_new = temp_sample.valid;
   // RQ8 pressure available
   wire p_da_d = p_new | (p_da_q & ~p_clr);
   // RQ6 pressure overrun
   wire p_or_d = (p_new & p_da_q & ~p_clr) | (p_or_q & ~p_clr);
   // RQ7 temperature available
   wire t_da_d = t_new | (t_da_q & ~t_clr);
   // RQ5 temperature overrun
   wire t_or_d = (t_new & t_da_q & ~t_clr) | (t_or_q & ~t_clr);
   wire [7:0] live_status = {2'b00, t_or_d, p_or_d, 2'b00, t_da_d, p_da_d};
   wire [7:0] clr_mask = ~({2'b00, t_clr, p_clr, 2'b00, t_clr, p_clr});

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= access;
         pslverr_q <= access & ~mapped;
         if (rd) begin
            prdata_q <= {24'h000000, rd_byte};
         end
      end
   end

   // RQ14 watermark register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         queue_ctrl_q <= `PSS_RST_BYTE;
         offset_low_q <= `PSS_RST_BYTE;
         offset_high_q <= `PSS_RST_BYTE;
         mode_ctrl_q <= `PSS_RST_BYTE;
      end else if (clk_en && wr) begin
         if (hit_qctrl) begin
            queue_ctrl_q <= pwdata[7:0];
         end
         if (hit_offl) begin
            offset_low_q <= pwdata[7:0];
         end
         if (hit_offh) begin
            offset_high_q <= pwdata[7:0];
         end
         if (hit_mode) begin
            mode_ctrl_q <= {4'h0, pwdata[3:0]};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         p_da_q <= 1'b0;
         p_or_q <= 1'b0;
         t_da_q <= 1'b0;
         t_or_q <= 1'b0;
      end else if (clk_en) begin
         p_da_q <= p_da_d;
         p_or_q <= p_or_d;
         t_da_q <= t_da_d;
         t_or_q <= t_or_d;
      end
   end

   // RQ9 status refresh
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sample_status_q <= `PSS_RST_BYTE;
      end else if (clk_en) begin
         if (odr_tick) begin
            sample_status_q <= live_status;
         end else begin
            sample_status_q <= sample_status_q & clr_mask;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         press_result_q <= `PSS_RST_PRESS;
         temp_result_q <= `PSS_RST_TEMP;
      end else if (clk_en) begin
         if (p_new) begin
            press_result_q <= press_d;
         end
         if (t_new) begin
            temp_result_q <= temp_sample.value;
         end
      end
   end

   pss_lpf #(
      .W(`PSS_PRESS_W),
      .SHIFT(`PSS_LPF_SHIFT)
   ) u_lpf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .enable(mode_ctrl_q[`PSS_MODE_LPF_BIT]),
      .restart(lpf_restart),
      .in_valid(press_sample.valid),
      .in_data(press_sample.value),
      .out_valid(lpf_valid),
      .out_data(lpf_data)
   );

   pss_level #(
      .DEPTH(`PSS_QUEUE_DEPTH),
      .LW(`PSS_LEVEL_W),
      .WMW(`PSS_WM_W)
   ) u_level (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .push(queue_push),
      .pop(queue_pop),
      .watermark_level(queue_ctrl_q[4:0]),
      .status(queue_stat)
   );

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule

// ==== pkg/pss_defs.svh ====
// register indices, field positions, reset values and sizes of the pressure readout block
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_IDX_QUEUE_CTRL 8'h14
`define PSS_IDX_OFFSET_LOW 8'h18
`define PSS_IDX_OFFSET_HIGH 8'h19
`define PSS_IDX_QUEUE_STATUS 8'h26
`define PSS_IDX_SAMPLE_STATUS 8'h27
`define PSS_IDX_PRESS_LOW 8'h28
`define PSS_IDX_PRESS_MID 8'h29
`define PSS_IDX_PRESS_HIGH 8'h2a
`define PSS_IDX_TEMP_LOW 8'h2b
`define PSS_IDX_TEMP_HIGH 8'h2c
`define PSS_IDX_FILTER_RESET 8'h33
`define PSS_IDX_MODE_CTRL 8'h40
`define PSS_QS_THR_BIT 7
`define PSS_QS_OVR_BIT 6
`define PSS_SS_TOR_BIT 5
`define PSS_SS_POR_BIT 4
`define PSS_SS_TDA_BIT 1
`define PSS_SS_PDA_BIT 0
`define PSS_MODE_DIFF_BIT 0
`define PSS_MODE_AZERO_BIT 1
`define PSS_MODE_AREF_BIT 2
`define PSS_MODE_LPF_BIT 3
`define PSS_QUEUE_DEPTH 32
`define PSS_LEVEL_W 6
`define PSS_WM_W 5
`define PSS_PRESS_W 24
`define PSS_TEMP_W 16
`define PSS_OFFSET_SHIFT 8
`define PSS_LPF_SHIFT 2
`define PSS_RST_BYTE 8'h00
`define PSS_RST_PRESS 24'h000000
`define PSS_RST_TEMP 16'h0000
`endif

// ==== pkg/pss_pkg.sv ====
// types shared by the pressure readout block
package pss_pkg;
   typedef struct packed {
      logic valid;
      logic [23:0] value;
   } pss_press_t;
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } pss_temp_t;
   typedef struct packed {
      logic threshold;
      logic overrun;
      logic [5:0] level;
   } pss_queue_stat_t;
   typedef enum logic [0:0] {
      LPF_EMPTY,
      LPF_RUN
   } pss_lpf_state_t;
endpackage

// ==== core/pss_level.sv ====
// queue fill level, threshold and overrun tracker
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_level #(
   parameter int DEPTH = `PSS_QUEUE_DEPTH,
   parameter int LW = `PSS_LEVEL_W,
   parameter int WMW = `PSS_WM_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic push,
   input wire logic pop,
   input wire logic [WMW-1:0] watermark_level,
   output pss_pkg::pss_queue_stat_t status
);
   localparam logic [LW-1:0] FULL = LW'(DEPTH);
   logic [LW-1:0] level_q;
   logic over_q;
   logic thr_q;
   wire full = (level_q == FULL);
   wire do_pop = pop & (level_q != '0);
   wire overwrite = push & full & ~do_pop;
   // RQ3 level count
   wire [LW-1:0] level_d = (push && !full && !do_pop) ? level_q + LW'(1) :
                           (do_pop && !push) ? level_q - LW'(1) : level_q;
   // RQ2 overrun sets
   wire over_d = overwrite | (over_q & ~do_pop);
   // RQ1 threshold compare
   wire thr_d = over_d | (level_d >= LW'(watermark_level));
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= '0;
         over_q <= 1'b0;
         thr_q <= 1'b0;
      end else if (clk_en) begin
         level_q <= level_d;
         over_q <= over_d;
         thr_q <= thr_d;
      end
   end
   // RQ4 overwrite forces
   assign status.threshold = thr_q | over_q;
   assign status.overrun = over_q;
   assign status.level = over_q ? FULL : level_q;
endmodule

// ==== core/pss_lpf.sv ====
// pressure low-pass filter with restart
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_lpf #(
   parameter int W = `PSS_PRESS_W,
   parameter int SHIFT = `PSS_LPF_SHIFT
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic enable,
   input wire logic restart,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   output logic [W-1:0] out_data
);
   pss_pkg::pss_lpf_state_t state_q;
   logic [W-1:0] acc_q;
   logic valid_q;
   wire signed [W:0] diff = $signed({in_data[W-1], in_data}) - $signed({acc_q[W-1], acc_q});
   wire signed [W:0] step = diff >>> SHIFT;
   wire [W-1:0] acc_run = acc_q + step[W-1:0];
   // first sample after a restart loads directly, skipping the settling ramp
   wire [W-1:0] acc_d = (!enable || state_q == pss_pkg::LPF_EMPTY) ? in_data : acc_run;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= pss_pkg::LPF_EMPTY;
         acc_q <= '0;
         valid_q <= 1'b0;
      end else if (clk_en) begin
         valid_q <= in_valid;
         case (state_q)
            pss_pkg::LPF_EMPTY: begin
               if (in_valid && enable && !restart) begin
                  state_q <= pss_pkg::LPF_RUN;
               end
            end
            pss_pkg::LPF_RUN: begin
               // RQ13 filter restart
               if (restart || !enable) begin
                  state_q <= pss_pkg::LPF_EMPTY;
               end
            end
            default: state_q <= pss_pkg::LPF_EMPTY;
         endcase
         if (in_valid) begin
            acc_q <= acc_d;
         end
      end
   end
   assign out_valid = valid_q;
   assign out_data = acc_q;
endmodule

// ==== sim/pss_top_monitor.sv ====
// concurrent checks on the readout block ports
`timescale 1ns/1ps
module pss_top_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire pss_pkg::pss_press_t press_sample,
   input wire pss_pkg::pss_temp_t temp_sample
);
   logic seen_p_q;
   logic seen_t_q;
   logic [4:0] wm_q;
   wire done = pready && psel && !pslverr;
   wire rd_qs = done && !pwrite && paddr[9:2] == 8'h26;
   wire rd_ss = done && !pwrite && paddr[9:2] == 8'h27;
   wire rd_fr = done && !pwrite && paddr[9:2] == 8'h33;
   wire wr_wm = done && pwrite && pstrb[0] && paddr[9:2] == 8'h14;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seen_p_q <= 1'b0;
         seen_t_q <= 1'b0;
         wm_q <= 5'h00;
      end else begin
         seen_p_q <= seen_p_q | press_sample.valid;
         seen_t_q <= seen_t_q | temp_sample.valid;
         wm_q <= wr_wm ? pwdata[4:0] : wm_q;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_access; psel && penable && !pready && clk_en; endsequence
   sequence s_ovr_read; rd_qs && prdata[6]; endsequence
   property p_wait; s_access |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("no answer after access cycle");
   property p_pulse; pready && clk_en |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read data not zero");
   property p_thr; rd_qs |-> prdata[7] == (prdata[5:0] >= {1'b0, wm_q}); endproperty
   a_thr: assert property (p_thr) else $error("threshold flag wrong");
   property p_level; rd_qs |-> prdata[5:0] <= 6'h20; endproperty
   a_level: assert property (p_level) else $error("level above full");
   property p_ovr; s_ovr_read |-> prdata[7] && prdata[5:0] == 6'h20; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun without full count");
   property p_por; rd_ss && prdata[4] |-> prdata[0]; endproperty
   a_por: assert property (p_por) else $error("pressure overrun alone");
   property p_tor; rd_ss && prdata[5] |-> prdata[1]; endproperty
   a_tor: assert property (p_tor) else $error("temperature overrun alone");
   property p_fresh; rd_ss |-> (seen_p_q || !prdata[0]) && (seen_t_q || !prdata[1]); endproperty
   a_fresh: assert property (p_fresh) else $error("available before any sample");
   property p_lpf; rd_fr |-> prdata[7:0] == 8'h00; endproperty
   a_lpf: assert property (p_lpf) else $error("filter reset reads nonzero");
endmodule
bind pss_top pss_top_monitor u_pss_top_monitor (
   .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .press_sample(press_sample), .temp_sample(temp_sample)
);

// ==== sim/pss_host.sv ====
// apb host model that reaches the readout registers
`timescale 1ns/1ps
module pss_host (
   input wire logic clk_sys,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [9:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   end
   // one transfer, request held until ready is seen at an edge or 16 edges pass
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err, output logic late);
      int i;
      late = 1'b1;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      pstrb <= 4'hf;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 16 && late; i++) begin
         @(posedge clk_sys);
         late = !(pready === 1'b1);
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== sim/pressure_sensor_status_output_test.sv ====
// self-checking bench for the pressure readout block
`timescale 1ns/1ps
module pressure_sensor_status_output_test;
   logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   pss_pkg::pss_press_t press_sample;
   pss_pkg::pss_temp_t temp_sample;
   logic odr_tick, queue_push, queue_pop, e, t, clk_en;
   int miscompares, num_checks, seed, k, w;
   logic [15:0] off;
   logic [23:0] a, b;
   logic [7:0] d;
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   pss_top u_pss_top (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .press_sample(press_sample),
      .temp_sample(temp_sample), .odr_tick(odr_tick), .queue_push(queue_push),
      .queue_pop(queue_pop));
   pss_host u_pss_host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   task automatic final_report;
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v);
      u_pss_host.xfer(w, idx, v, d, e, t);
      chk({8'h00, t}, 9'h000);
      if (t) final_report();
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] x);
      acc(1'b0, idx, 8'h00);
      chk({e, d}, {1'b0, x});
   endtask
   task automatic rdp(input logic [23:0] v);
      rd(8'h28, v[7:0]);
      rd(8'h29, v[15:8]);
      rd(8'h2a, v[23:16]);
   endtask
   // sel: 0 pressure, 1 temperature, 2 data period, 3 push, 4 pop
   task automatic pulse(input int sel, input logic [23:0] v);
      @(posedge clk_sys);
      press_sample <= {sel == 0, v};
      temp_sample <= {sel == 1, v[15:0]};
      odr_tick <= sel == 2;
      queue_push <= sel == 3;
      queue_pop <= sel == 4;
      @(posedge clk_sys);
      {press_sample, temp_sample, odr_tick, queue_push, queue_pop} <= '0;
   endtask
   function automatic logic [7:0] expq(input int n, input int wm);
      int l;
      l = n > 32 ? 32 : n;
      return {l >= wm, n > 32, 6'(l)};
   endfunction
   // difference taken one bit wider so opposite signs cannot wrap
   function automatic logic [23:0] filt(input logic [23:0] y, input logic [23:0] x);
      logic signed [24:0] dd;
      dd = $signed({x[23], x}) - $signed({y[23], y});
      return y + 24'(dd >>> 2);
   endfunction
   initial begin
      seed = 87542;
      rst_n = 1'b0;
      clk_en = 1'b1;
      {press_sample, temp_sample, odr_tick, queue_push, queue_pop} = '0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(8'h26, 8'h80);
      rd(8'h27, 8'h00);
      for (k = 8'h28; k <= 8'h2c; k++) rd(8'(k), 8'h00);
      acc(1'b0, 8'h3f, 8'h00);
      chk({e, d}, 9'h100);
      w = {$random(seed)} % 31 + 1;
      acc(1'b1, 8'h14, 8'(w));
      acc(1'b1, 8'h26, 8'hff);
      for (k = 1; k <= 33; k++) begin
         pulse(3, 24'h0);
         rd(8'h26, expq(k, w));
      end
      pulse(4, 24'h0);
      rd(8'h26, expq(31, w));
      // a push while the clock enable is low must leave the level alone
      clk_en <= 1'b0;
      pulse(3, 24'h0);
      clk_en <= 1'b1;
      rd(8'h26, expq(31, w));
      off = 16'($random(seed));
      acc(1'b1, 8'h18, off[7:0]);
      acc(1'b1, 8'h19, off[15:8]);
      a = 24'($random(seed));
      b = 24'($random(seed));
      pulse(0, a);
      rd(8'h27, 8'h00);
      pulse(2, 24'h0);
      rd(8'h27, 8'h01);
      pulse(0, b);
      pulse(2, 24'h0);
      rd(8'h27, 8'h11);
      rdp(b - {off, 8'h00});
      rd(8'h27, 8'h00);
      pulse(1, a);
      pulse(2, 24'h0);
      pulse(1, b);
      pulse(2, 24'h0);
      rd(8'h27, 8'h22);
      rd(8'h2b, b[7:0]);
      rd(8'h2c, b[15:8]);
      rd(8'h27, 8'h00);
      for (k = 0; k < 3; k++) begin
         acc(1'b1, 8'h40, 8'(1 << k));
         pulse(0, a);
         rdp(a);
      end
      acc(1'b1, 8'h18, 8'h00);
      acc(1'b1, 8'h19, 8'h00);
      acc(1'b1, 8'h40, 8'h08);
      for (k = 0; k < 3; k++) begin
         rd(8'h33, 8'h00);
         a = 24'($random(seed));
         b = 24'($random(seed));
         pulse(0, a);
         rdp(a);
         pulse(0, b);
         rdp(filt(a, b));
      end
      final_report();
   end
endmodule
